/* dac_cmd_pkg.sv */
// constants, command codes and frame layout for the dac serial command port
// assumes a single system clock that oversamples the serial link pins
package dac_cmd_pkg;
    localparam int FRAME_BITS = 16;
    localparam int DATA_BITS = 10;
    localparam int NUM_CHAN = 4;
    localparam int ADDR_MSB = 15;
    localparam int CTRL_LSB = 12;
    localparam int DATA_MSB = 13 - 2;
    localparam int DATA_LSB = 2;
    localparam logic [4:0] CNT_FULL = 5'h10;

    // address/control codes
    localparam logic [3:0] CODE_NOP = 4'h0;
    localparam logic [3:0] CODE_UPDATE = 4'h4;
    localparam logic [3:0] CODE_LOAD_ALL = 4'h8;
    localparam logic [3:0] CODE_SHUTDOWN = 4'hC;
    localparam logic [3:0] CODE_UPO_LO = 4'h2;
    localparam logic [3:0] CODE_UPO_HI = 4'h6;
    localparam logic [3:0] CODE_MODE1 = 4'hE;
    localparam logic [3:0] CODE_MODE0 = 4'hA;
    localparam logic [1:0] CTRL_LOAD = 2'h1;
    localparam logic [1:0] CTRL_LOAD_UPD = 2'h3;

    typedef struct packed {
        logic [1:0] addr;
        logic [1:0] ctrl;
        logic [9:0] data;
        logic [1:0] sub;
    } frame_s;

    typedef struct packed {
        logic load_one;
        logic load_all;
        logic update;
        logic wake;
        logic sleep;
        logic upo_set;
        logic upo_val;
        logic mode_set;
        logic mode_val;
    } action_s;
endpackage : dac_cmd_pkg

/* pin_sync.sv */
// two flip-flop synchroniser for a group of pins
// assumes pins are asynchronous to mclk_i
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] reset_val_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    // idle levels substitute until the second stage holds a real pin value
    logic [1:0] primed_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            primed_q <= 2'b00;
        end else begin
            primed_q <= {primed_q[0], 1'b1};
        end
    end
    assign sync_o = primed_q[1] ? sync_q : reset_val_i;
endmodule : pin_sync

/* dac_regs.sv */
// four-channel double-buffered input and dac registers
// assumes decoded one-cycle actions from the command port
module dac_regs
    import dac_cmd_pkg::*;
#(
    parameter int CHANS = NUM_CHAN,
    parameter int WIDTH = DATA_BITS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire action_s act_i,
    input wire logic [1:0] addr_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [CHANS*WIDTH-1:0] input_regs_o,
    output logic [CHANS*WIDTH-1:0] dac_regs_o
);
    if (CHANS != 4) begin : g_bad_chans
        $error("dac_regs: two address bits serve four channels");
    end

    genvar g;
    generate
        for (g = 0; g < CHANS; g++) begin : g_chan
            logic [WIDTH-1:0] in_q;
            logic [WIDTH-1:0] dac_q;
            logic [WIDTH-1:0] in_d;
            wire hit = act_i.load_one && (addr_i == 2'(g));
            assign in_d = (act_i.load_all || hit) ? data_i : in_q;
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    in_q <= '0;
                    dac_q <= '0;
                end else if (clr_i) begin
                    in_q <= '0;
                    dac_q <= '0;
                end else begin
                    in_q <= in_d;
                    if (act_i.load_all) begin
                        dac_q <= data_i;
                    end else if (act_i.update) begin
                        dac_q <= in_d;
                    end
                end
            end
            assign input_regs_o[g*WIDTH +: WIDTH] = in_q;
            assign dac_regs_o[g*WIDTH +: WIDTH] = dac_q;
        end
    endgenerate
endmodule : dac_regs

/* dac_cmd_port.sv */
// serial command port of a four-channel 10-bit dac
// assumes serial clock far slower than mclk_i (>= 4 samples per half period)
module dac_cmd_port
    import dac_cmd_pkg::*;
(
    // system
    input wire logic mclk_i,
    input wire logic rst_i,
    // serial link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    // control pins
    input wire logic clear_n_i,
    input wire logic shutdown_lockout_n_i,
    // status and outputs
    output logic user_logic_out_o,
    output logic shutdown_o,
    output logic out_mode_o,
    output logic [NUM_CHAN*DATA_BITS-1:0] input_regs_o,
    output logic [NUM_CHAN*DATA_BITS-1:0] dac_regs_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pins_s;
    pin_sync #(.WIDTH(5)) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .async_i({sclk_i, cs_n_i, din_i, clear_n_i, shutdown_lockout_n_i}),
        .reset_val_i(5'h0B),
        .sync_o(pins_s)
    );
    wire sclk_s = pins_s[4];
    wire cs_n_s = pins_s[3];
    wire din_s = pins_s[2];
    wire clear_n_s = pins_s[1];
    wire lock_n_s = pins_s[0];

    logic sclk_q;
    logic cs_n_q;
    logic lock_n_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            lock_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
            lock_n_q <= lock_n_s;
        end
    end
    wire clr = ~clear_n_s;
    wire sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
    wire sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;
    wire cs_rise = cs_n_s & ~cs_n_q;
    wire lock_fall = ~lock_n_s & lock_n_q;

    // ------------------------------------------------------------
    // shift register and bit counter
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] shift_q;
    logic [FRAME_BITS-1:0] shift_d;
    logic [4:0] count_q;
    logic [4:0] count_d;
    wire count_sat = (count_q == 5'h1F);

    assign shift_d = sclk_rise ? {shift_q[FRAME_BITS-2:0], din_s} : shift_q;
    assign count_d = cs_n_s ? 5'h00 :
                     (sclk_rise && !count_sat) ? count_q + 5'h01 : count_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= '0;
            count_q <= '0;
        end else if (clr) begin
            shift_q <= '0;
            count_q <= '0;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    frame_s frame;
    assign frame = shift_q;
    wire [3:0] code = {frame.addr, frame.ctrl};
    wire frame_ok = cs_rise && (count_q == CNT_FULL);

    function automatic logic is_code(input logic [3:0] c, input logic [3:0] k);
        is_code = (c == k);
    endfunction : is_code

    action_s act;
    assign act.load_one = frame_ok && (frame.ctrl == CTRL_LOAD ||
                                       frame.ctrl == CTRL_LOAD_UPD);
    assign act.load_all = frame_ok && is_code(code, CODE_LOAD_ALL);
    assign act.update = frame_ok && (frame.ctrl == CTRL_LOAD_UPD ||
                        is_code(code, CODE_UPDATE) ||
                        is_code(code, CODE_MODE1) ||
                        is_code(code, CODE_MODE0));
    assign act.wake = frame_ok && (is_code(code, CODE_UPDATE) ||
                                   is_code(code, CODE_LOAD_ALL));
    assign act.sleep = frame_ok && is_code(code, CODE_SHUTDOWN) &&
                       lock_n_s;
    assign act.upo_set = frame_ok && (is_code(code, CODE_UPO_LO) ||
                                      is_code(code, CODE_UPO_HI));
    assign act.upo_val = is_code(code, CODE_UPO_HI);
    assign act.mode_set = frame_ok && (is_code(code, CODE_MODE1) ||
                                       is_code(code, CODE_MODE0));
    assign act.mode_val = is_code(code, CODE_MODE1);
    // code 0000 and unlisted codes leave every register alone

    // ------------------------------------------------------------
    // registers and control state
    // ------------------------------------------------------------
    logic [NUM_CHAN*DATA_BITS-1:0] in_w;
    logic [NUM_CHAN*DATA_BITS-1:0] dac_w;
    dac_regs u_regs (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clr_i(clr),
        .act_i(act),
        .addr_i(frame.addr),
        .data_i(frame.data),
        .input_regs_o(in_w),
        .dac_regs_o(dac_w)
    );

    logic shutdown_q;
    logic upo_q;
    logic mode_q;
    logic shutdown_d;
    // wake by lockout edge beats a same-cycle shutdown command
    assign shutdown_d = (lock_fall || act.wake) ? 1'b0 :
                        act.sleep ? 1'b1 : shutdown_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            shutdown_q <= 1'b0;
            upo_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            shutdown_q <= shutdown_d;
            if (clr) begin
                upo_q <= 1'b0;
            end else if (act.upo_set) begin
                upo_q <= act.upo_val;
            end
            if (act.mode_set) begin
                mode_q <= act.mode_val;
            end
        end
    end

    // ------------------------------------------------------------
    // serial output and registered outputs
    // ------------------------------------------------------------
    logic dout_q;
    logic last_q;
    logic [NUM_CHAN*DATA_BITS-1:0] in_o_q;
    logic [NUM_CHAN*DATA_BITS-1:0] dac_o_q;
    wire dout_edge = mode_q ? sclk_rise : sclk_fall;
    // mode 0 re-times the bit that left the register at the last rise
    wire dout_d = mode_q ? shift_q[FRAME_BITS-1] : last_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_q <= 1'b0;
            last_q <= 1'b0;
            in_o_q <= '0;
            dac_o_q <= '0;
        end else begin
            if (clr) begin
                dout_q <= 1'b0;
                last_q <= 1'b0;
            end else begin
                if (sclk_rise) begin
                    last_q <= shift_q[FRAME_BITS-1];
                end
                if (dout_edge) begin
                    dout_q <= dout_d;
                end
            end
            in_o_q <= in_w;
            dac_o_q <= dac_w;
        end
    end

    assign dout_o = dout_q;
    assign user_logic_out_o = upo_q;
    assign shutdown_o = shutdown_q;
    assign out_mode_o = mode_q;
    assign input_regs_o = in_o_q;
    assign dac_regs_o = dac_o_q;
endmodule : dac_cmd_port

/* dac_cmd_port_monitor.sv */
// assertions on the pins of the dac serial command port
// assumes sclk_i half period of at least four mclk_i cycles
module dac_cmd_port_monitor
    import dac_cmd_pkg::*;
(
    // system
    input wire logic mclk_i,
    input wire logic rst_i,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic dout_o,
    // control
    input wire logic clear_n_i,
    input wire logic shutdown_lockout_n_i,
    // status
    input wire logic user_logic_out_o,
    input wire logic shutdown_o,
    input wire logic out_mode_o,
    input wire logic [NUM_CHAN*DATA_BITS-1:0] input_regs_o,
    input wire logic [NUM_CHAN*DATA_BITS-1:0] dac_regs_o
);
    // ----------
    // pin relations
    // ----------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    reset_state_a:
    assert property ($fell(rst_i) |-> !out_mode_o && !shutdown_o
        && !user_logic_out_o && input_regs_o == '0 && dac_regs_o == '0)
        else $error("state not zero after reset");
    idle_hold_a:
    assert property ((cs_n_i && clear_n_i)[*8] |=> $stable(input_regs_o)
        && $stable(dac_regs_o) && $stable({user_logic_out_o, out_mode_o}))
        else $error("state moved while deselected");
    busy_hold_a:
    assert property ((!cs_n_i && clear_n_i)[*8] |=> $stable(input_regs_o)
        && $stable(dac_regs_o) && $stable(user_logic_out_o))
        else $error("state moved before frame end");
    clear_zero_a:
    assert property ((!clear_n_i)[*6] |-> input_regs_o == '0
        && dac_regs_o == '0 && !user_logic_out_o && !dout_o)
        else $error("clear did not zero outputs");
    lock_block_a:
    assert property ((!shutdown_lockout_n_i)[*8] |-> !shutdown_o)
        else $error("shutdown while locked out");
    sleep_keep_a:
    assert property ($rose(shutdown_o) |-> $stable(input_regs_o)
        && $stable(dac_regs_o))
        else $error("registers moved on shutdown");
    echo_rise_a:
    assert property (out_mode_o && $changed(dout_o) && clear_n_i
        && $past(clear_n_i, 4) |-> $past(sclk_i, 2))
        else $error("dout moved off rising edge");
    echo_fall_a:
    assert property (!out_mode_o && $changed(dout_o) && clear_n_i
        && $past(clear_n_i, 4) |-> !$past(sclk_i, 2))
        else $error("dout moved off falling edge");
endmodule : dac_cmd_port_monitor

bind dac_cmd_port dac_cmd_port_monitor mon (.mclk_i, .rst_i, .sclk_i,
    .cs_n_i, .din_i, .dout_o, .clear_n_i, .shutdown_lockout_n_i,
    .user_logic_out_o, .shutdown_o, .out_mode_o, .input_regs_o, .dac_regs_o);

/* host_model.sv */
// behavioural serial host driving the command port link pins
// assumes a 200 ns link period, unrelated in phase to mclk_i
module host_model (
    // serial link
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // frame driver
    // ----------
    logic [15:0] echo = 16'h0000;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // echo taken late in the half period after the mode's output edge
    task automatic send(input logic [15:0] w, input int n,
        input logic split, input logic m);
        #7 cs_n_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            din_o = w[i];
            #100 if (!m && i != 15) echo = {echo[14:0], dout_i};
            sclk_o = 1'b1;
            #100 if (m) echo = {echo[14:0], dout_i};
            sclk_o = 1'b0;
            if (split && i == 8) #300;
        end
        #100 if (!m) echo = {echo[14:0], dout_i};
        cs_n_o = 1'b1;
        din_o = ~din_o;
    endtask : send
    task automatic stray();
        repeat (4) begin
            #100 din_o = ~din_o;
            sclk_o = 1'b1;
            #100 sclk_o = 1'b0;
        end
    endtask : stray
endmodule : host_model

/* tb.sv */
// self-checking bench for the dac serial command port
// assumes host_model drives the link pins
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // bench
    // ----------
    typedef struct {
        logic [15:0] w;
        logic [39:0] ir;
        logic [39:0] dr;
        logic [2:0] s;
    } row_s;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic clear_n_i = 1'b1;
    logic shutdown_lockout_n_i = 1'b1;
    logic sclk_i, cs_n_i, din_i, dout_o, user_logic_out_o;
    logic shutdown_o, out_mode_o;
    logic [39:0] input_regs_o, dac_regs_o;
    logic [82:0] st, x;
    logic [15:0] prev = 16'h0000;
    logic cur_mode = 1'b0;
    int miscompares = 0;
    int n_tests = 0;
    row_s rows [15] = '{
        '{16'h1FFC, 40'h00000003FF, 40'h0000000000, 3'h0},
        '{16'h5554, 40'h00000557FF, 40'h0000000000, 3'h0},
        '{16'hBAA8, 40'h002AA557FF, 40'h002AA557FF, 3'h0},
        '{16'hD004, 40'h006AA557FF, 40'h002AA557FF, 3'h0},
        '{16'hC000, 40'h006AA557FF, 40'h002AA557FF, 3'h1},
        '{16'h4000, 40'h006AA557FF, 40'h006AA557FF, 3'h0},
        '{16'h6000, 40'h006AA557FF, 40'h006AA557FF, 3'h4},
        '{16'h1000, 40'h006AA55400, 40'h006AA557FF, 3'h4},
        '{16'hE000, 40'h006AA55400, 40'h006AA55400, 3'h6},
        '{16'h52AC, 40'h006AA2AC00, 40'h006AA55400, 3'h6},
        '{16'hA000, 40'h006AA2AC00, 40'h006AA2AC00, 3'h4},
        '{16'h2000, 40'h006AA2AC00, 40'h006AA2AC00, 3'h0},
        '{16'h0FFC, 40'h006AA2AC00, 40'h006AA2AC00, 3'h0},
        '{16'hC000, 40'h006AA2AC00, 40'h006AA2AC00, 3'h1},
        '{16'h8800, 40'h8020080200, 40'h8020080200, 3'h0}};
    assign st = {input_regs_o, dac_regs_o, user_logic_out_o, out_mode_o,
        shutdown_o};
    always #12.5 mclk_i = ~mclk_i;
    host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i),
        .dout_i(dout_o));
    dac_cmd_port dut (.mclk_i, .rst_i, .sclk_i, .cs_n_i, .din_i, .dout_o,
        .clear_n_i, .shutdown_lockout_n_i, .user_logic_out_o, .shutdown_o,
        .out_mode_o, .input_regs_o, .dac_regs_o);
    task automatic cmp(input logic [82:0] got, input logic [82:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : cmp
    task automatic frame(input logic [15:0] w, input int n);
        host.send(w, n, n_tests[0], cur_mode);
        repeat (8) @(posedge mclk_i);
    endtask : frame
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        cmp(st, 83'h0);
        foreach (rows[i]) begin
            frame(rows[i].w, 16);
            x = {rows[i].ir, rows[i].dr, rows[i].s};
            cmp(st[82:43], x[82:43]);
            cmp(st[42:0], x[42:0]);
            cmp(host.echo, prev);
            prev = rows[i].w;
            cur_mode = x[1];
            $display("row %0d done", i);
        end
        frame(16'h1000, 12);
        host.stray();
        cmp(st, x);
        $display("partial frame test done");
        shutdown_lockout_n_i <= 1'b0;
        frame(16'hC000, 16);
        cmp(shutdown_o, 1'b0);
        shutdown_lockout_n_i <= 1'b1;
        frame(16'hC000, 16);
        cmp(shutdown_o, 1'b1);
        shutdown_lockout_n_i <= 1'b0;
        for (int k = 0; k < 20 && shutdown_o !== 1'b0; k++) @(posedge mclk_i);
        if (shutdown_o !== 1'b0) begin
            miscompares++;
            final_report();
        end
        cmp(st, x);
        $display("lockout test done");
        frame(16'h6000, 16);
        frame(16'hE000, 16);
        clear_n_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        cmp(st, 83'h2);
        cmp(dout_o, 1'b0);
        clear_n_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        cmp(st, 83'h0);
        $display("clear and reset test done");
        final_report();
    end
endmodule : tb
